// ---- logic/sram_host.v ----
`timescale 1ns/1ps
`include "sram_host_defines.vh"

// Functional notes
// - Write opens at last active control edge
// - Host meets address setup before write
// - Host changes address only after write ends
// - Strobe-ended write samples at strobe rise
// - Select-ended write samples at select edge (host writes always end on strobe rise; sram_model samples only at strobe rise)
// - Host keeps output gate high unless reading
module sram_host #(
    parameter READ_CYCLES  = `READ_CYC,
    parameter WRITE_CYCLES = `WRITE_CYC,
    parameter FLOAT_CYCLES = `FLOAT_CYC
) (
    input  wire               core_clk,
    input  wire               rst_b,
    input  wire               req_valid,
    output wire               req_ready,
    input  wire               req_write,
    input  wire [`ADDR_W-1:0] req_addr,
    input  wire [`DATA_W-1:0] req_wdata,
    output reg                rsp_valid,
    output reg  [`DATA_W-1:0] rsp_rdata,
    output reg  [`ADDR_W-1:0] word_select_lines,
    output reg                select_active_low_b,
    output reg                select_active_high,
    output reg                write_strobe_b,
    output reg                output_gate_b,
    input  wire [`DATA_W-1:0] shared_data_in,
    output reg  [`DATA_W-1:0] shared_data_out,
    output reg                shared_data_oe
);

// ---------------------------------------------------------------
// States
// ---------------------------------------------------------------
localparam [2:0] S_IDLE   = 3'h0;
localparam [2:0] S_RD     = 3'h1;
localparam [2:0] S_WR_SET = 3'h2;
localparam [2:0] S_WR     = 3'h3;
localparam [2:0] S_WR_END = 3'h4;
localparam [2:0] S_FLOAT  = 3'h5;

reg [2:0]         state_q;
reg [7:0]         cnt_q;
reg [`DATA_W-1:0] din_s1_q;
reg [`DATA_W-1:0] din_s2_q;

// ---------------------------------------------------------------
// Counter helpers
// ---------------------------------------------------------------
// Terminal count of one phase, cut to the counter width
function [7:0] end_count;
    input [31:0] cycles;
    input [7:0]  extra;
    begin
        end_count = cycles[7:0] + extra;
    end
endfunction

// Step that saturates, so a stuck phase never wraps to zero
function [7:0] step_count;
    input [7:0] count;
    begin
        if (count == 8'hFF) begin
            step_count = count;
        end else begin
            step_count = count + 8'h01;
        end
    end
endfunction

// ---------------------------------------------------------------
// Phase ends
// ---------------------------------------------------------------
// Read also waits out the two synchroniser stages
localparam [7:0] READ_END  = end_count(READ_CYCLES, 8'h02);
localparam [7:0] WRITE_END = end_count(WRITE_CYCLES, 8'h00);
localparam [7:0] FLOAT_END = end_count(FLOAT_CYCLES, 8'h00);

wire rd_end;
wire wr_end;
wire float_end;

assign rd_end    = (cnt_q == READ_END);
assign wr_end    = (cnt_q == WRITE_END);
assign float_end = (cnt_q == FLOAT_END);

assign req_ready = (state_q == S_IDLE);

// ---------------------------------------------------------------
// Data input synchroniser
// ---------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        din_s1_q <= 8'h00;
        din_s2_q <= 8'h00;
    end else begin
        din_s1_q <= shared_data_in;
        din_s2_q <= din_s1_q;
    end
end

// ---------------------------------------------------------------
// Cycle sequencer
// ---------------------------------------------------------------
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        state_q             <= S_IDLE;
        cnt_q               <= 8'h00;
        rsp_valid           <= 1'b0;
        rsp_rdata           <= 8'h00;
        word_select_lines   <= 13'h0000;
        select_active_low_b <= 1'b1;   // Deselected at rest
        select_active_high  <= 1'b0;
        write_strobe_b      <= 1'b1;
        output_gate_b       <= 1'b1;
        shared_data_out     <= 8'h00;
        shared_data_oe      <= 1'b0;
    end else begin
        rsp_valid <= 1'b0;
        case (state_q)
            S_IDLE: begin
                if (req_valid) begin
                    // Address and data settle one cycle before the write strobe; a read opens with the address
                    word_select_lines <= req_addr;
                    cnt_q             <= 8'h00;
                    if (req_write) begin
                        shared_data_out <= req_wdata;
                        shared_data_oe  <= 1'b1;
                        state_q         <= S_WR_SET;
                    end else begin
                        // Low select and gate low, high select high, open the read
                        select_active_low_b <= 1'b0;
                        select_active_high  <= 1'b1;
                        output_gate_b       <= 1'b0;
                        state_q             <= S_RD;
                    end
                end
            end
            S_RD: begin
                // Wait the full access plus two sync stages
                if (rd_end) begin
                    rsp_rdata           <= din_s2_q;
                    rsp_valid           <= 1'b1;
                    output_gate_b       <= 1'b1;
                    select_active_low_b <= 1'b1;
                    select_active_high  <= 1'b0;
                    cnt_q               <= 8'h00;
                    state_q             <= S_FLOAT;
                end else begin
                    cnt_q <= step_count(cnt_q);
                end
            end
            S_WR_SET: begin
                // Strobe low before selects, gate high: memory stays floating
                write_strobe_b <= 1'b0;
                state_q        <= S_WR;
            end
            S_WR: begin
                // Selects open the write last
                select_active_low_b <= 1'b0;
                select_active_high  <= 1'b1;
                if (wr_end) begin
                    // Strobe rise ends the write; data held past it
                    write_strobe_b <= 1'b1;
                    cnt_q          <= 8'h00;
                    state_q        <= S_WR_END;
                end else begin
                    cnt_q <= step_count(cnt_q);
                end
            end
            S_WR_END: begin
                // Deselect and release data in the same cycle, before address moves
                select_active_low_b <= 1'b1;
                select_active_high  <= 1'b0;
                shared_data_oe      <= 1'b0;
                rsp_valid           <= 1'b1;
                state_q             <= S_IDLE;
            end
            S_FLOAT: begin
                // Let memory drivers float before next cycle
                // Pins already idle; keep them so
                select_active_low_b <= 1'b1;
                select_active_high  <= 1'b0;
                output_gate_b       <= 1'b1;
                if (float_end) begin
                    state_q <= S_IDLE;
                end else begin
                    cnt_q <= step_count(cnt_q);
                end
            end
            default: begin
                // Unknown state: park the pins and go idle
                select_active_low_b <= 1'b1;
                select_active_high  <= 1'b0;
                write_strobe_b      <= 1'b1;
                output_gate_b       <= 1'b1;
                shared_data_oe      <= 1'b0;
                state_q             <= S_IDLE;
            end
        endcase
    end
end

endmodule // sram_host

// ---- logic/sram_host_defines.vh ----
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH

// Clock period in ps (50 MHz)
`define CLK_PERIOD_PS          20000
// Device timing figures, ns (slowest grade)
`define T_READ_CYCLE_NS        120
`define T_WRITE_PULSE_NS       70
`define T_DATA_SETUP_NS        40
`define T_ADDR_SETUP_END_NS    85
`define T_WRITE_TO_FLOAT_NS    40
`define T_DISABLE_FLOAT_NS     40
// Least times round up to whole cycles
`define CYC_UP(ns)             ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_CYC               `CYC_UP(`T_READ_CYCLE_NS)
`define WRITE_CYC              `CYC_UP(`T_ADDR_SETUP_END_NS)
`define FLOAT_CYC              `CYC_UP(`T_DISABLE_FLOAT_NS)

`define ADDR_W                 13
`define DATA_W                 8

`endif

// ---- test/sram_host_bench.sv ----
`timescale 1ns/1ps
module sram_host_bench;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         req_valid = 1'b0;
    reg         req_write = 1'b0;
    reg  [12:0] req_addr = 13'h0000;
    reg  [7:0]  req_wdata = 8'h00;
    wire        rdy, rsp, sel_lo_b, sel_hi, wstb_b, gate_b, oe;
    wire [7:0]  rdata, dout, bus;
    wire [12:0] pins;
    integer     num_errors = 0;
    integer     check_count = 0;
    always #10 core_clk = ~core_clk;
    sram_host #(.READ_CYCLES(6), .WRITE_CYCLES(5), .FLOAT_CYCLES(2)) sram_host_i (
        .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(rdy),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp), .rsp_rdata(rdata), .word_select_lines(pins),
        .select_active_low_b(sel_lo_b), .select_active_high(sel_hi),
        .write_strobe_b(wstb_b), .output_gate_b(gate_b), .shared_data_in(bus),
        .shared_data_out(dout), .shared_data_oe(oe));
    sram_model sram_model_i (.core_clk(core_clk), .word_select_lines(pins),
        .select_active_low_b(sel_lo_b), .select_active_high(sel_hi),
        .write_strobe_b(wstb_b), .output_gate_b(gate_b), .host_data(dout),
        .host_oe(oe), .bus_level(bus));
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task check(input string what, input [7:0] exp, input [7:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Writes store d; reads expect d; latency counted from the take edge
    task xfer(input w, input [12:0] a, input [7:0] d);
        integer n;
        while (rdy !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n = n + 1;
        end
        check("latency", w ? 8'h08 : 8'h09, n[7:0]);
        if (!w) check("read data", d, rdata);
    endtask
    // ----
    // Scenarios
    // ----
    task test_boundary;
        xfer(1'b1, 13'h0000, 8'hA5);
        xfer(1'b1, 13'h1FFF, 8'h5A);
        xfer(1'b0, 13'h0000, 8'hA5);
        xfer(1'b0, 13'h1FFF, 8'h5A);
    endtask
    task test_overwrite;
        xfer(1'b1, 13'h0555, 8'h0F);
        xfer(1'b1, 13'h0AAA, 8'h3C);
        xfer(1'b1, 13'h0AAA, 8'hC3);
        xfer(1'b0, 13'h0AAA, 8'hC3);
        xfer(1'b0, 13'h0555, 8'h0F);
    endtask
    initial begin
        #20000 num_errors = num_errors + 1;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        test_boundary;
        test_overwrite;
        finish_test;
    end
endmodule // sram_host_bench

// ---- test/sram_host_sva.sv ----
`timescale 1ns/1ps
module sram_host_sva (
    input wire        core_clk,
    input wire        rst_b,
    input wire [12:0] word_select_lines,
    input wire        select_active_low_b,
    input wire        select_active_high,
    input wire        write_strobe_b,
    input wire        output_gate_b,
    input wire [7:0]  shared_data_out,
    input wire        shared_data_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_WR_OPEN: assert property ($fell(write_strobe_b) |-> select_active_low_b && shared_data_oe)
        else $error("strobe fell while selected or undriven");
    AST_ADDR_SETUP: assert property ($fell(select_active_low_b) && !write_strobe_b |-> $stable(word_select_lines))
        else $error("address moved at write start");
    AST_ADDR_HOLD: assert property (!write_strobe_b |=> $stable(word_select_lines))
        else $error("address moved during write");
    AST_DATA_HOLD: assert property (!write_strobe_b |=> shared_data_oe && $stable(shared_data_out))
        else $error("write data not held to strobe rise");
    AST_WR_CLOSE: assert property ($rose(write_strobe_b) |=> select_active_low_b && !shared_data_oe)
        else $error("write not closed after strobe rise");
    AST_GATE: assert property (!output_gate_b |-> write_strobe_b && !shared_data_oe)
        else $error("output gate low outside a read");
    AST_SEL_PAIR: assert property (select_active_low_b == !select_active_high)
        else $error("selects not moved as a pair");
endmodule // sram_host_sva
bind sram_host sram_host_sva sram_host_sva_i (
    .core_clk(core_clk), .rst_b(rst_b), .word_select_lines(word_select_lines),
    .select_active_low_b(select_active_low_b), .select_active_high(select_active_high),
    .write_strobe_b(write_strobe_b),
    .output_gate_b(output_gate_b), .shared_data_out(shared_data_out),
    .shared_data_oe(shared_data_oe));

// ---- test/sram_model.sv ----
`timescale 1ns/1ps
// ----
// Memory device seen from the pins
// ----
module sram_model (
    input  wire        core_clk,
    input  wire [12:0] word_select_lines,
    input  wire        select_active_low_b,
    input  wire        select_active_high,
    input  wire        write_strobe_b,
    input  wire        output_gate_b,
    input  wire [7:0]  host_data,
    input  wire        host_oe,
    output wire [7:0]  bus_level
);
    reg  [7:0] mem [0:8191];
    reg  [7:0] last_q;
    wire       sel = !select_active_low_b && select_active_high;
    wire       drv = sel && !output_gate_b && write_strobe_b;
    // Floating bus shows a changing pattern
    assign bus_level = host_oe ? host_data : drv ? mem[word_select_lines] : ~last_q;
    always @(posedge core_clk) last_q <= bus_level;
    always @(posedge write_strobe_b) if (sel) mem[word_select_lines] <= host_data;
endmodule // sram_model
